// >>> logic/occ_defines.svh
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH
// Summary of operation
// [R1] time base is one of two timers, picked by time_base_select
// [R2] modes match against one compare value or a pair of them
// [R3] a count equal to a compare value changes the pin per mode
// [R4] mode 000 disables the channel, releases the pin, no interrupt
// [R5] 001 low then high on match, rising irq; 010 the mirror, falling irq
// [R6] 011 keeps the level on entry, inverts per match, irq on both edges
// [R7] 100 one pulse, 101 continuous pulses; start low, falling-edge irq
// [R8] 110 pwm, no irq; starts low if primary value zero, else high
// [R9] 111 pwm as 110; channels one to four interrupt on fault falling edge
// [R10] compare match events raise interrupt requests per mode edge table
// [R11] software stops the timer before rewriting the control register
// [R12] only channels one and two may request a dma transfer
// [R13] idle_stop_select set halts the channel while the cpu idles
// [R14] compare_mode_field sits in control bits 2:0, eight codes
// [R15] fault_status set on pwm fault in 111; only hardware clears it
// [R16] pwm period follows the timer; primary value match drives pin low

// ==========================================================
// register byte offsets
`define OCC_OFF_CTRL 8'h00
`define OCC_OFF_PRI  8'h04
`define OCC_OFF_SEC  8'h08
`define OCC_OFF_STAT 8'h0c
`define OCC_OFF_CLR  8'h10
`define OCC_OFF_EN   8'h14
`define OCC_OFF_PIN  8'h18

// ==========================================================
// field positions and widths
`define OCC_BIT_IDLE 13
`define OCC_BIT_FLT  4
`define OCC_BIT_TSEL 3
`define OCC_IRQ_W    2
`define OCC_EVT_CMP  0
`define OCC_EVT_FLT  1

// ==========================================================
// reset values and channel limits
`define OCC_RST_CMP     16'h0000
`define OCC_RST_IRQ     2'h0
`define OCC_CNT_ZERO    16'h0000
`define OCC_DMA_LAST_CH 4'h2
`define OCC_FLT_LAST_CH 4'h4
`define OCC_FIRST_CH    4'h1
`endif

// >>> logic/occ_pkg.sv
package occ_pkg;
  // ==========================================================
  // mode codes of compare_mode_field
  typedef enum logic [2:0] {
    OCC_OFF     = 3'b000,
    OCC_ONE_HI  = 3'b001,
    OCC_ONE_LO  = 3'b010,
    OCC_TOGGLE  = 3'b011,
    OCC_DELAY   = 3'b100,
    OCC_PULSE   = 3'b101,
    OCC_PWM     = 3'b110,
    OCC_PWM_FLT = 3'b111
  } occ_mode_e;

  // sequencing state for the one-shot and pulse modes
  typedef enum logic [1:0] {
    OCC_ST_IDLE = 2'b00,
    OCC_ST_ARM  = 2'b01,
    OCC_ST_HIGH = 2'b10,
    OCC_ST_DONE = 2'b11
  } occ_state_e;

  // output_compare_control fields that hold state
  typedef struct packed {
    logic      idle_stop;
    logic      fault;
    logic      tsel;
    occ_mode_e mode;
  } occ_ctrl_s;

  // edge pair from the edge detector
  typedef struct packed {
    logic rise;
    logic fall;
  } occ_edge_s;
endpackage

// >>> logic/occ_edge.sv
`timescale 1ns/1ps
module occ_edge #(
  parameter logic INIT = 1'b0
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              level,
  output occ_pkg::occ_edge_s     edges
);
  logic prev_reg;

  // ==========================================================
  // previous level, reset to the idle level so no false edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev_reg <= INIT;
    end else begin
      prev_reg <= level;
    end
  end

  // edges compare the live level against the stored one
  assign edges.rise = level & ~prev_reg;
  assign edges.fall = ~level & prev_reg;
endmodule

// >>> logic/occ_top.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "occ_defines.svh"
module occ_top #(
  parameter logic [3:0] CHANNEL_ID = 4'h1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] tmr_a_count,
  input  wire logic [15:0] tmr_b_count,
  input  wire logic        cpu_idle,
  input  wire logic        shared_fault_input,
  output logic             oc_pin_out,
  output logic             oc_pin_oe_n,
  output logic             irq,
  output logic             dma_req
);
  occ_pkg::occ_ctrl_s          ctrl_reg;
  occ_pkg::occ_state_e         st_reg;
  occ_pkg::occ_mode_e          prev_mode_reg;
  occ_pkg::occ_edge_s          pin_edge;
  occ_pkg::occ_edge_s          flt_edge;
  logic [15:0]                 pri_reg;
  logic [15:0]                 sec_reg;
  logic [15:0]                 count;
  logic [`OCC_IRQ_W-1:0]       stat_reg;
  logic [`OCC_IRQ_W-1:0]       stat_next;
  logic [`OCC_IRQ_W-1:0]       en_reg;
  logic [`OCC_IRQ_W-1:0]       clr_mask;
  logic [`OCC_IRQ_W-1:0]       evt;
  logic                        pin_reg;
  logic                        access;
  logic                        wr;
  logic                        run;
  logic                        mode_chg;
  logic                        m_pri;
  logic                        m_sec;
  logic                        m_zero;
  logic                        m_pri_reg;
  logic                        m_sec_reg;
  logic                        m_zero_reg;
  logic                        hit_pri;
  logic                        hit_sec;
  logic                        hit_zero;
  logic                        flt_hold;

  // ==========================================================
  // helpers
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `OCC_OFF_CTRL) || (a == `OCC_OFF_PRI) ||
              (a == `OCC_OFF_SEC)  || (a == `OCC_OFF_STAT) ||
              (a == `OCC_OFF_CLR)  || (a == `OCC_OFF_EN) ||
              (a == `OCC_OFF_PIN);
  endfunction

  // level that the pin takes when a mode is entered
  function automatic logic init_pin(input occ_pkg::occ_mode_e m,
                                    input logic [15:0] pri,
                                    input logic cur);
    case (m)
      occ_pkg::OCC_ONE_LO:  init_pin = 1'b1;                      // [R5]
      occ_pkg::OCC_TOGGLE:  init_pin = cur;                       // [R6]
      occ_pkg::OCC_PWM,
      occ_pkg::OCC_PWM_FLT: init_pin = (pri != `OCC_RST_CMP);     // [R8]
      default:              init_pin = 1'b0;                      // [R5]
    endcase
  endfunction

  // read mux; the clear register reads back zero
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `OCC_OFF_CTRL: begin
        v[`OCC_BIT_IDLE] = ctrl_reg.idle_stop;
        v[`OCC_BIT_FLT]  = ctrl_reg.fault;
        v[`OCC_BIT_TSEL] = ctrl_reg.tsel;
        v[2:0]           = ctrl_reg.mode;                         // [R14]
      end
      `OCC_OFF_PRI:  v[15:0] = pri_reg;
      `OCC_OFF_SEC:  v[15:0] = sec_reg;
      `OCC_OFF_STAT: v[`OCC_IRQ_W-1:0] = stat_reg;
      `OCC_OFF_EN:   v[`OCC_IRQ_W-1:0] = en_reg;
      `OCC_OFF_PIN:  v[3:0] = {st_reg, ~oc_pin_oe_n, pin_reg};
      default:       v = 32'h0000_0000;
    endcase
    rd_word = v;
  endfunction

  // ==========================================================
  // apb decode: one wait state, answer on the second access cycle
  assign access = psel && penable && !pready;
  assign wr     = access && pwrite && addr_ok(paddr);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access && !addr_ok(paddr);
      prdata  <= (access && !pwrite) ? rd_word(paddr) : 32'h0000_0000;
    end
  end

  // ==========================================================
  // control register; fault bit is never written by software
  // reconfiguring with the timer running may glitch the pin [R11]
  // fault status lives here too so the struct has a single driver;
  // set by a fault edge, released at a period start once the input
  // is back high; a set beats a release
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_reg.idle_stop <= 1'b0;
      ctrl_reg.fault     <= 1'b0;
      ctrl_reg.tsel      <= 1'b0;
      ctrl_reg.mode      <= occ_pkg::OCC_OFF;
    end else begin
      if (wr && paddr == `OCC_OFF_CTRL) begin
        ctrl_reg.idle_stop <= pwdata[`OCC_BIT_IDLE];              // [R13]
        ctrl_reg.tsel      <= pwdata[`OCC_BIT_TSEL];              // [R1]
        ctrl_reg.mode      <= occ_pkg::occ_mode_e'(pwdata[2:0]);  // [R14]
      end
      if (ctrl_reg.mode == occ_pkg::OCC_PWM_FLT && flt_edge.fall) begin
        ctrl_reg.fault <= 1'b1;                                   // [R15]
      end else if (ctrl_reg.mode != occ_pkg::OCC_PWM_FLT ||
                   (hit_zero && shared_fault_input)) begin
        ctrl_reg.fault <= 1'b0;                                   // [R15]
      end
    end
  end

  // compare values and interrupt enables
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pri_reg <= `OCC_RST_CMP;
      sec_reg <= `OCC_RST_CMP;
      en_reg  <= `OCC_RST_IRQ;
    end else if (wr) begin
      if (paddr == `OCC_OFF_PRI) pri_reg <= pwdata[15:0];
      if (paddr == `OCC_OFF_SEC) sec_reg <= pwdata[15:0];
      if (paddr == `OCC_OFF_EN)  en_reg  <= pwdata[`OCC_IRQ_W-1:0];
    end
  end

  // ==========================================================
  // time base and match detection
  assign count = ctrl_reg.tsel ? tmr_b_count : tmr_a_count;       // [R1]
  assign run   = (ctrl_reg.mode != occ_pkg::OCC_OFF) &&
                 !(cpu_idle && ctrl_reg.idle_stop);               // [R13]
  assign mode_chg = (ctrl_reg.mode != prev_mode_reg);
  assign m_pri  = run && (count == pri_reg);                      // [R3]
  assign m_sec  = run && (count == sec_reg);                      // [R2]
  assign m_zero = run && (count == `OCC_CNT_ZERO);                // [R16]
  // a prescaled timer holds a count for many cycles: act once per entry
  assign hit_pri  = m_pri && !m_pri_reg;
  assign hit_sec  = m_sec && !m_sec_reg;
  assign hit_zero = m_zero && !m_zero_reg;
  assign flt_hold = (ctrl_reg.mode == occ_pkg::OCC_PWM_FLT) &&
                    ctrl_reg.fault;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      m_pri_reg     <= 1'b0;
      m_sec_reg     <= 1'b0;
      m_zero_reg    <= 1'b0;
      prev_mode_reg <= occ_pkg::OCC_OFF;
    end else begin
      m_pri_reg     <= m_pri;
      m_sec_reg     <= m_sec;
      m_zero_reg    <= m_zero;
      prev_mode_reg <= ctrl_reg.mode;
    end
  end

  // ==========================================================
  // pin sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_reg <= 1'b0;
      st_reg  <= occ_pkg::OCC_ST_IDLE;
    end else if (mode_chg) begin
      pin_reg <= init_pin(ctrl_reg.mode, pri_reg, pin_reg);
      st_reg  <= occ_pkg::OCC_ST_ARM;
    end else if (run) begin
      case (ctrl_reg.mode)
        occ_pkg::OCC_ONE_HI: begin
          if (st_reg == occ_pkg::OCC_ST_ARM && hit_pri) begin
            pin_reg <= 1'b1;                                      // [R5]
            st_reg  <= occ_pkg::OCC_ST_DONE;
          end
        end
        occ_pkg::OCC_ONE_LO: begin
          if (st_reg == occ_pkg::OCC_ST_ARM && hit_pri) begin
            pin_reg <= 1'b0;                                      // [R5]
            st_reg  <= occ_pkg::OCC_ST_DONE;
          end
        end
        occ_pkg::OCC_TOGGLE: begin
          if (hit_pri) begin
            pin_reg <= ~pin_reg;                                  // [R6]
          end
        end
        occ_pkg::OCC_DELAY,
        occ_pkg::OCC_PULSE: begin
          if (st_reg == occ_pkg::OCC_ST_ARM && hit_pri) begin
            pin_reg <= 1'b1;                                      // [R7]
            st_reg  <= occ_pkg::OCC_ST_HIGH;
          end else if (st_reg == occ_pkg::OCC_ST_HIGH && hit_sec) begin
            pin_reg <= 1'b0;                                      // [R7]
            st_reg  <= (ctrl_reg.mode == occ_pkg::OCC_PULSE) ?
                       occ_pkg::OCC_ST_ARM : occ_pkg::OCC_ST_DONE;
          end
        end
        occ_pkg::OCC_PWM,
        occ_pkg::OCC_PWM_FLT: begin
          // primary match ahead of the period start so a zero duty keeps the pin low
          if (flt_hold) begin
            pin_reg <= 1'b0;                                      // [R9]
          end else if (hit_pri) begin
            pin_reg <= 1'b0;                                      // [R16]
          end else if (hit_zero) begin
            pin_reg <= (pri_reg != `OCC_RST_CMP);                 // [R16]
          end
        end
        default: begin
          pin_reg <= pin_reg;
        end
      endcase
    end
  end

  // ==========================================================
  // edge detectors on the pin and on the fault input
  occ_edge #(
    .INIT (1'b0)
  ) u_pin_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .level   (pin_reg),
    .edges   (pin_edge)
  );

  occ_edge #(
    .INIT (1'b1)
  ) u_flt_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .level   (shared_fault_input),
    .edges   (flt_edge)
  );

  // ==========================================================
  // interrupt events per mode edge table
  always_comb begin
    evt = `OCC_RST_IRQ;
    case (ctrl_reg.mode)
      occ_pkg::OCC_ONE_HI: evt[`OCC_EVT_CMP] = pin_edge.rise;     // [R5]
      occ_pkg::OCC_ONE_LO: evt[`OCC_EVT_CMP] = pin_edge.fall;     // [R5]
      occ_pkg::OCC_TOGGLE:
        evt[`OCC_EVT_CMP] = pin_edge.rise | pin_edge.fall;        // [R6]
      occ_pkg::OCC_DELAY,
      occ_pkg::OCC_PULSE:  evt[`OCC_EVT_CMP] = pin_edge.fall;     // [R7]
      occ_pkg::OCC_PWM_FLT:
        evt[`OCC_EVT_FLT] = flt_edge.fall &&
                            CHANNEL_ID >= `OCC_FIRST_CH &&
                            CHANNEL_ID <= `OCC_FLT_LAST_CH;       // [R9]
      default: evt = `OCC_RST_IRQ;                                // [R4] [R8]
    endcase
  end

  // write-one-to-clear, a same-cycle event wins over the clear
  assign clr_mask  = (wr && paddr == `OCC_OFF_CLR) ?
                     pwdata[`OCC_IRQ_W-1:0] : `OCC_RST_IRQ;
  assign stat_next = (stat_reg & ~clr_mask) | evt;                // [R10]

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stat_reg <= `OCC_RST_IRQ;
      irq      <= 1'b0;
      dma_req  <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq      <= |(stat_next & en_reg);                          // [R10]
      dma_req  <= evt[`OCC_EVT_CMP] &&
                  CHANNEL_ID >= `OCC_FIRST_CH &&
                  CHANNEL_ID <= `OCC_DMA_LAST_CH;                 // [R12]
    end
  end

  // pin drivers; enable is low while the channel owns the pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oc_pin_out  <= 1'b0;
      oc_pin_oe_n <= 1'b1;
    end else begin
      oc_pin_out  <= pin_reg;
      oc_pin_oe_n <= (ctrl_reg.mode == occ_pkg::OCC_OFF);         // [R4]
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_pulse_arm;
    ctrl_reg.mode == occ_pkg::OCC_PULSE && run && !mode_chg &&
    st_reg == occ_pkg::OCC_ST_ARM && hit_pri;
  endsequence

  sequence s_pulse_high;
    st_reg == occ_pkg::OCC_ST_HIGH && pin_reg;
  endsequence

  a_off_release: assert property (                                // [R4]
    ctrl_reg.mode == occ_pkg::OCC_OFF |=> oc_pin_oe_n)
    else $error("pin not released in disabled mode");

  a_one_hi_set: assert property (                                 // [R5]
    ctrl_reg.mode == occ_pkg::OCC_ONE_HI && run && !mode_chg &&
    st_reg == occ_pkg::OCC_ST_ARM && hit_pri |=> pin_reg ##1 oc_pin_out)
    else $error("one-shot high missed its match");

  a_toggle_inv: assert property (                                 // [R6]
    ctrl_reg.mode == occ_pkg::OCC_TOGGLE && run && !mode_chg && hit_pri
    |=> pin_reg != $past(pin_reg))
    else $error("toggle did not invert pin");

  a_pulse_steps: assert property (s_pulse_arm |=> s_pulse_high)   // [R7]
    else $error("pulse did not rise on primary match");

  a_pwm_entry: assert property (                                  // [R8]
    mode_chg && ctrl_reg.mode == occ_pkg::OCC_PWM
    |=> pin_reg == ($past(pri_reg) != `OCC_RST_CMP))
    else $error("pwm entry level wrong");

  a_fault_low: assert property (                                  // [R9]
    flt_hold && run && !mode_chg |=> !pin_reg)
    else $error("pin not low under fault");

  a_pwm_duty: assert property (                                   // [R16]
    ctrl_reg.mode == occ_pkg::OCC_PWM && run && !mode_chg && hit_pri
    |=> !pin_reg)
    else $error("pwm duty match did not drive low");

  a_fault_hw: assert property (                                   // [R15]
    $rose(ctrl_reg.fault) |-> $past(flt_edge.fall) &&
    $past(ctrl_reg.mode) == occ_pkg::OCC_PWM_FLT)
    else $error("fault status set without fault edge");

  a_stat_sticky: assert property (                                // [R10]
    evt[`OCC_EVT_CMP] |=> stat_reg[`OCC_EVT_CMP] &&
    (irq || !$past(en_reg[`OCC_EVT_CMP])))
    else $error("compare event lost");

  a_dma_none: assert property (                                   // [R12]
    dma_req |-> CHANNEL_ID <= `OCC_DMA_LAST_CH &&
    $past(evt[`OCC_EVT_CMP]))
    else $error("dma request from a channel without dma");

  a_idle_hold: assert property (                                  // [R13]
    (cpu_idle && ctrl_reg.idle_stop && !mode_chg) [*2] |->
    $stable(pin_reg))
    else $error("channel moved while halted in idle");

  a_mode_write: assert property (                                 // [R14]
    wr && paddr == `OCC_OFF_CTRL |=> ctrl_reg.mode == $past(pwdata[2:0]))
    else $error("mode field not taken from bits 2:0");
endmodule

// >>> bench/occ_load_model.sv
`timescale 1ns/1ps
// ==========================================================
// load on the compare pin
module occ_load_model (
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  input  wire logic port_level,
  output logic      pad
);
  // a released pin shows the port level, never a stale driven value
  assign pad = pin_oe_n ? port_level : pin_out;
endmodule

// >>> bench/output_compare_channel_tb.sv
`timescale 1ns/1ps
module output_compare_channel_tb;
  // ==========================================================
  // stimulus and observation
  typedef struct packed {
    logic [2:0] mode;
    logic       tsel;
    logic [1:0] en;
    logic       mid;
    logic       fin;
    logic       st;
  } occ_row_s;

  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] tmr_a_count = 16'h0000;
  logic [15:0] tmr_b_count = 16'h0000;
  logic        cpu_idle = 1'b0;
  logic        shared_fault_input = 1'b1;
  logic        oc_pin_out;
  logic        oc_pin_oe_n;
  logic        irq;
  logic        dma_req;
  logic        pad;
  logic        mid;
  logic [31:0] rd;
  logic        er;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          dma_cnt = 0;
  occ_row_s    rows [9];

  occ_top #(.CHANNEL_ID(4'h1)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tmr_a_count(tmr_a_count),
    .tmr_b_count(tmr_b_count), .cpu_idle(cpu_idle),
    .shared_fault_input(shared_fault_input), .oc_pin_out(oc_pin_out),
    .oc_pin_oe_n(oc_pin_oe_n), .irq(irq), .dma_req(dma_req)
  );

  occ_load_model load (
    .pin_out(oc_pin_out), .pin_oe_n(oc_pin_oe_n), .port_level(1'b1),
    .pad(pad)
  );

  always #5 ref_clk = ~ref_clk;

  // dma pulses last one cycle, so count them at every edge
  always @(posedge ref_clk) begin
    if (dma_req === 1'b1) begin
      dma_cnt++;
    end
  end

  // ==========================================================
  // shared tasks
  task conclude;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // timer stopped at zero while control is rewritten; the other at 3
  task do_reset(input logic sel);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    tmr_a_count <= sel ? 16'h0003 : 16'h0000;
    tmr_b_count <= sel ? 16'h0000 : 16'h0003;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    dma_cnt = 0;
  endtask

  task ramp(input logic sel);
    for (int i = 0; i <= 20; i++) begin
      @(posedge ref_clk);
      if (i == 9) begin
        mid = pad;
      end
      if (sel) begin
        tmr_b_count <= i[15:0];
      end else begin
        tmr_a_count <= i[15:0];
      end
    end
    repeat (4) @(posedge ref_clk);
  endtask

  // a hang ends the run as a failure
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end

  // ==========================================================
  // main sequence
  initial begin
    rows[0] = '{3'b001, 1'b0, 2'h1, 1'b1, 1'b1, 1'b1};
    rows[1] = '{3'b001, 1'b1, 2'h1, 1'b1, 1'b1, 1'b1};
    rows[2] = '{3'b001, 1'b0, 2'h0, 1'b1, 1'b1, 1'b1};
    rows[3] = '{3'b010, 1'b0, 2'h1, 1'b0, 1'b0, 1'b1};
    rows[4] = '{3'b011, 1'b0, 2'h1, 1'b1, 1'b1, 1'b1};
    rows[5] = '{3'b100, 1'b0, 2'h1, 1'b1, 1'b0, 1'b1};
    rows[6] = '{3'b101, 1'b0, 2'h1, 1'b1, 1'b0, 1'b1};
    rows[7] = '{3'b110, 1'b0, 2'h1, 1'b0, 1'b0, 1'b0};
    rows[8] = '{3'b000, 1'b0, 2'h1, 1'b1, 1'b1, 1'b0};
    do_reset(1'b0);
    // reset values, then the unmapped word just past the map
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, er}, {31'h0, i == 7});
    end
    // ordinary cases: primary 5, secondary 10, one timer ramp
    foreach (rows[k]) begin
      do_reset(rows[k].tsel);
      apb(1'b1, 8'h04, 32'h5);
      apb(1'b1, 8'h08, 32'ha);
      apb(1'b1, 8'h14, {30'h0, rows[k].en});
      apb(1'b1, 8'h00, {28'h0, rows[k].tsel, rows[k].mode});
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, {28'h0, rows[k].tsel, rows[k].mode});
      ramp(rows[k].tsel);
      chk({31'h0, mid}, {31'h0, rows[k].mid});
      chk({31'h0, pad}, {31'h0, rows[k].fin});
      chk({31'h0, oc_pin_oe_n}, {31'h0, rows[k].mode == 3'b000});
      chk({31'h0, irq}, {31'h0, rows[k].st & rows[k].en[0]});
      chk(dma_cnt, {31'h0, rows[k].st});
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, {31'h0, rows[k].st});
    end
    // fault in pwm mode: software cannot set the fault bit
    do_reset(1'b0);
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b1, 8'h14, 32'h3);
    apb(1'b1, 8'h00, 32'h17);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h7);
    chk({31'h0, oc_pin_out}, 32'h1);
    shared_fault_input <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({31'h0, oc_pin_out}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h17);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // hardware clears the fault at a new period with the input high
    shared_fault_input <= 1'b1;
    tmr_a_count <= 16'h0001;
    @(posedge ref_clk);
    tmr_a_count <= 16'h0000;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h7);
    // idle stop: no match while the cpu idles, resumes after
    do_reset(1'b0);
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b1, 8'h00, 32'h2001);
    cpu_idle <= 1'b1;
    ramp(1'b0);
    chk({31'h0, oc_pin_out}, 32'h0);
    cpu_idle <= 1'b0;
    tmr_a_count <= 16'h0000;
    ramp(1'b0);
    chk({31'h0, oc_pin_out}, 32'h1);
    conclude();
  end
endmodule
